// File: logic/rom_top.sv
// Purpose: Output override, freeze and command monitor
// Assumes: Threshold and standstill levels synchronous to pclk
// Notes:   Registers over APB, zero wait states
`timescale 1ns/1ps
module rom_top (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Front key and remote input
    input  wire logic        key_up,
    input  wire logic        control_input_one,
    // Comparator side
    input  wire logic [2:0]  thr_active,
    input  wire logic        speed_moving,
    input  wire logic        speed_below_low,
    input  wire logic        standstill,
    // Outputs
    output logic             switch_output_one,
    output logic             switch_output_two,
    output logic             switch_output_three,
    output logic             motion_disabled_ind
);
    // ------------------------------------------------------------
    // Registers and synchroniser
    // ------------------------------------------------------------
    logic [31:0] ctrl_reg, mode_reg, delay_reg, still_reg, status;
    logic [31:0] prdata_c;
    logic        pready_c, pslverr_c;
    logic [31:0] prdata_reg;
    logic        pready_reg, pslverr_reg, en_edge;
    logic [1:0]  sync_q;
    logic [2:0]  out_reg, out_next, frz_reg, comp;
    logic        alarm_reg, alarm_next, en_prev_reg, mon_on;
    logic        act, freeze, en_lvl, trig_key, trig_in;
    logic [31:0] dly_cnt_reg, still_cnt_reg;
    logic [3:0]  sel;
    logic [2:0]  pat, opol;
    logic [2:0]  under_sel;
    rom_pkg::rom_mon_e st_reg;

    rom_apb u_apb (
        .pclk      (pclk),
        .presetn   (presetn),
        .psel      (psel),
        .penable   (penable),
        .pwrite    (pwrite),
        .paddr     (paddr),
        .pwdata    (pwdata),
        .prdata    (prdata_c),
        .pready    (pready_c),
        .pslverr   (pslverr_c),
        .status    (status),
        .ctrl_reg  (ctrl_reg),
        .mode_reg  (mode_reg),
        .delay_reg (delay_reg),
        .still_reg (still_reg)
    );
    rom_sync #(.W(2)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({control_input_one, key_up}),
        .q       (sync_q)
    );

    // ------------------------------------------------------------
    // Registered bus answer
    // ------------------------------------------------------------
    // Taken in the setup cycle, stands through the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= 32'h0000_0000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else if (psel && !penable) begin
            prdata_reg  <= prdata_c;
            pready_reg  <= pready_c;
            pslverr_reg <= pslverr_c;
        end else begin
            prdata_reg  <= 32'h0000_0000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end
    end
    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;
    assign status  = {26'h0, alarm_reg, motion_disabled_ind, out_reg[2], out_reg[1], out_reg[0], mon_on};

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    assign sel      = ctrl_reg[rom_pkg::CTRL_SEL_LSB +: 4];
    assign pat      = ctrl_reg[rom_pkg::CTRL_PAT_LSB +: 3];
    assign opol     = ctrl_reg[rom_pkg::CTRL_OPOL_LSB +: 3];
    assign trig_key = (ctrl_reg[rom_pkg::CTRL_KEYF_LSB +: 4] == rom_pkg::FUNC_ACTION) && sync_q[0];
    assign trig_in  = (ctrl_reg[rom_pkg::CTRL_IN1F_LSB +: 4] == rom_pkg::FUNC_ACTION) && sync_q[1];
    assign act      = trig_key || trig_in;
    assign freeze   = act && (sel == rom_pkg::SEL_FREEZE);
    assign mon_on   = ctrl_reg[rom_pkg::CTRL_IN1F_LSB +: 4] == rom_pkg::FUNC_MONITOR;
    assign en_lvl   = sync_q[1] ^ ctrl_reg[rom_pkg::CTRL_IN1P_BIT];
    assign en_edge  = mon_on && (en_lvl != en_prev_reg);

    // Underspeed output select per mode field
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_under
            assign under_sel[g] = mode_reg[4*g +: 2] == rom_pkg::MODE_UNDER;
        end
    endgenerate

    // ------------------------------------------------------------
    // Command monitor
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_prev_reg <= 1'b0;
        end else begin
            en_prev_reg <= en_lvl;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg        <= rom_pkg::ROM_IDLE;
            dly_cnt_reg   <= 32'h0000_0000;
            still_cnt_reg <= 32'h0000_0000;
        end else if (!mon_on) begin
            st_reg        <= rom_pkg::ROM_IDLE;
            dly_cnt_reg   <= 32'h0000_0000;
            still_cnt_reg <= 32'h0000_0000;
        end else if (en_lvl != en_prev_reg) begin
            st_reg        <= en_lvl ? rom_pkg::ROM_RUN : rom_pkg::ROM_STOP;
            dly_cnt_reg   <= delay_reg;
            still_cnt_reg <= still_reg;
        end else begin
            case (st_reg)
                rom_pkg::ROM_IDLE: begin
                    st_reg        <= en_lvl ? rom_pkg::ROM_RUN : rom_pkg::ROM_STOP;
                    dly_cnt_reg   <= delay_reg;
                    still_cnt_reg <= still_reg;
                end
                default: st_reg <= st_reg;
            endcase
            if (dly_cnt_reg != 32'h0000_0000) dly_cnt_reg <= dly_cnt_reg - 32'h0000_0001;
            if (still_cnt_reg != 32'h0000_0000) still_cnt_reg <= still_cnt_reg - 32'h0000_0001;
        end
    end

    always_comb begin
        alarm_next = 1'b0;
        case (st_reg)
            rom_pkg::ROM_RUN:
                alarm_next = (dly_cnt_reg == 32'h0000_0000) && (!speed_moving || speed_below_low);
            rom_pkg::ROM_STOP: begin
                if (still_cnt_reg == 32'h0000_0000 && !standstill) alarm_next = 1'b1;
                if (dly_cnt_reg == 32'h0000_0000 && speed_moving && still_cnt_reg == 32'h0000_0000)
                    alarm_next = 1'b1;
            end
            default: alarm_next = 1'b0;
        endcase
        if (!mon_on || en_edge) alarm_next = 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_reg           <= 1'b0;
            motion_disabled_ind <= 1'b0;
        end else begin
            alarm_reg           <= alarm_next;
            motion_disabled_ind <= mon_on && !en_lvl;
        end
    end

    // ------------------------------------------------------------
    // Output override and freeze
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            comp[i] = (thr_active[i] || (mon_on && under_sel[i] && alarm_reg)) ^ opol[i];
        end
        out_next = comp;
        if (freeze) begin
            out_next = frz_reg;
        end else if (act) begin
            for (int i = 0; i < 3; i++) begin
                if (sel[i]) out_next[i] = pat[i];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_reg <= 3'h0;
            frz_reg <= 3'h0;
        end else begin
            out_reg <= out_next;
            if (!freeze) frz_reg <= out_next;
        end
    end
    assign switch_output_one   = out_reg[0];
    assign switch_output_two   = out_reg[1];
    assign switch_output_three = out_reg[2];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Enable level changes while the monitor is on
    sequence s_en_change;
        mon_on && (en_lvl != en_prev_reg);
    endsequence
    // Disabled, both timers run out, drive still turning
    sequence s_stop_moving;
        mon_on && (st_reg == rom_pkg::ROM_STOP) && (en_lvl == en_prev_reg) && speed_moving
            && (dly_cnt_reg == 32'h0000_0000) && (still_cnt_reg == 32'h0000_0000);
    endsequence
    // Enabled, start-up delay over, speed under the window
    sequence s_run_slow;
        mon_on && (st_reg == rom_pkg::ROM_RUN) && (en_lvl == en_prev_reg)
            && (dly_cnt_reg == 32'h0000_0000) && (!speed_moving || speed_below_low);
    endsequence

    property p_freeze_hold;
        @(posedge pclk) disable iff (!presetn)
            freeze && $past(freeze) |=> $stable(out_reg);
    endproperty
    property p_override_lvl;
        @(posedge pclk) disable iff (!presetn)
            act && !freeze && sel[0] |=> out_reg[0] == $past(pat[0]);
    endproperty
    property p_select_keep;
        @(posedge pclk) disable iff (!presetn)
            act && !freeze && !sel[1] |=> out_reg[1] == $past(comp[1]);
    endproperty
    property p_release_now;
        @(posedge pclk) disable iff (!presetn)
            !act |=> out_reg == $past(comp);
    endproperty
    property p_status_dis;
        @(posedge pclk) disable iff (!presetn)
            mon_on && !en_lvl |=> motion_disabled_ind;
    endproperty
    property p_delay_quiet;
        @(posedge pclk) disable iff (!presetn)
            mon_on && en_lvl && !en_prev_reg |=> !alarm_reg;
    endproperty
    property p_edge_quiet;
        @(posedge pclk) disable iff (!presetn)
            s_en_change |=> !alarm_reg;
    endproperty
    property p_stop_moving;
        @(posedge pclk) disable iff (!presetn)
            s_stop_moving |=> alarm_reg;
    endproperty
    property p_run_slow;
        @(posedge pclk) disable iff (!presetn)
            s_run_slow |=> alarm_reg;
    endproperty
    property p_still_load;
        @(posedge pclk) disable iff (!presetn)
            s_en_change ##0 !en_lvl |=> still_cnt_reg == $past(still_reg);
    endproperty
    property p_idle_quiet;
        @(posedge pclk) disable iff (!presetn)
            !mon_on |=> !alarm_reg;
    endproperty
    property p_alarm_under;
        @(posedge pclk) disable iff (!presetn)
            mon_on && alarm_reg && under_sel[1] && !act |=> out_reg[1] == !$past(opol[1]);
    endproperty
    property p_bus_answer;
        @(posedge pclk) disable iff (!presetn)
            psel && !penable |=> pready;
    endproperty

    // ------------------------------------------------------------
    // Labelled checks
    // ------------------------------------------------------------
    a_freeze_hold: assert property (p_freeze_hold) else $error("freeze not held");
    a_override_lvl: assert property (p_override_lvl) else $error("override level");
    a_select_keep: assert property (p_select_keep) else $error("unselected output overridden");
    a_release_now: assert property (p_release_now) else $error("release slow");
    a_status_dis: assert property (p_status_dis) else $error("status");
    a_delay_quiet: assert property (p_delay_quiet) else $error("delay");
    a_edge_quiet: assert property (p_edge_quiet) else $error("alarm at enable change");
    a_stop_moving: assert property (p_stop_moving) else $error("no alarm while moving");
    a_run_slow: assert property (p_run_slow) else $error("no alarm below window");
    a_still_load: assert property (p_still_load) else $error("standstill time not loaded");
    a_idle_quiet: assert property (p_idle_quiet) else $error("alarm with monitor off");
    a_alarm_under: assert property (p_alarm_under) else $error("alarm not on underspeed output");
    a_bus_answer: assert property (p_bus_answer) else $error("no ready in access cycle");
endmodule

// File: common/rom_pkg.sv
// Purpose: Constants for the relay override and motion monitor block
// Assumes: 25 MHz pclk, APB register access
// Notes:   Functional notes below
package rom_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_MODE    = 8'h04;
    localparam logic [7:0] OFS_DELAY   = 8'h08;
    localparam logic [7:0] OFS_STILL   = 8'h0C;
    localparam logic [7:0] OFS_STATUS  = 8'h10;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_SEL_LSB   = 0;   // output select, 4 bits
    localparam int CTRL_PAT_LSB   = 4;   // action pattern, 3 bits
    localparam int CTRL_OPOL_LSB  = 8;   // output polarity, 3 bits
    localparam int CTRL_KEYF_LSB  = 12;  // up key function, 4 bits
    localparam int CTRL_IN1F_LSB  = 16;  // input one function, 4 bits
    localparam int CTRL_IN1P_BIT  = 20;  // input one polarity
    localparam int MODE_M1_LSB    = 0;   // output one mode, 2 bits
    localparam int MODE_M2_LSB    = 4;
    localparam int MODE_M3_LSB    = 8;
    // ------------------------------------------------------------
    // Codes and reset values
    // ------------------------------------------------------------
    localparam logic [3:0] FUNC_ACTION  = 4'h2;
    localparam logic [3:0] FUNC_MONITOR = 4'hC;
    localparam logic [3:0] SEL_FREEZE   = 4'h8;
    localparam logic [1:0] MODE_OVER    = 2'h0;
    localparam logic [1:0] MODE_UNDER   = 2'h1;
    localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
    localparam logic [31:0] MODE_RST    = 32'h0000_0110;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ        = 25;
    localparam int DELAY_MS_RST   = 100;
    localparam int STILL_MS_RST   = 1000;
    localparam logic [31:0] DELAY_CYC_RST = 32'(DELAY_MS_RST * CLK_MHZ * 1000);
    localparam logic [31:0] STILL_CYC_RST = 32'(STILL_MS_RST * CLK_MHZ * 1000);
    typedef enum logic [2:0] {
        ROM_IDLE = 3'b001,
        ROM_RUN  = 3'b010,
        ROM_STOP = 3'b100
    } rom_mon_e;
endpackage

// File: logic/rom_sync.sv
// Purpose: Two flip-flop synchroniser per bit
// Assumes: Asynchronous inputs
// Notes:   First stage read only by second
`timescale 1ns/1ps
module rom_sync #(
    parameter int W = 2
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
    generate
        if (W < 1) begin : g_bad_w
            $error("rom_sync needs W of at least 1");
        end
    endgenerate
endmodule

// File: logic/rom_apb.sv
// Purpose: APB register file
// Assumes: Zero wait states, pslverr on unmapped address
// Notes:   Status is read only
`timescale 1ns/1ps
module rom_apb (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Register values
    input  wire logic [31:0] status,
    output logic      [31:0] ctrl_reg,
    output logic      [31:0] mode_reg,
    output logic      [31:0] delay_reg,
    output logic      [31:0] still_reg
);
    logic acc;
    logic hit;
    assign acc = psel && penable;
    always_comb begin
        if (paddr == rom_pkg::OFS_CTRL) hit = 1'b1;
        else if (paddr == rom_pkg::OFS_MODE) hit = 1'b1;
        else if (paddr == rom_pkg::OFS_DELAY) hit = 1'b1;
        else if (paddr == rom_pkg::OFS_STILL) hit = 1'b1;
        else if (paddr == rom_pkg::OFS_STATUS) hit = 1'b1;
        else hit = 1'b0;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg  <= rom_pkg::CTRL_RST;
            mode_reg  <= rom_pkg::MODE_RST;
            delay_reg <= rom_pkg::DELAY_CYC_RST;
            still_reg <= rom_pkg::STILL_CYC_RST;
        end else if (acc && pwrite) begin
            if (paddr == rom_pkg::OFS_CTRL) ctrl_reg <= pwdata;
            else if (paddr == rom_pkg::OFS_MODE) mode_reg <= pwdata;
            else if (paddr == rom_pkg::OFS_DELAY) delay_reg <= pwdata;
            else if (paddr == rom_pkg::OFS_STILL) still_reg <= pwdata;
        end
    end
    always_comb begin
        pready  = 1'b1;
        pslverr = psel && !hit;
        if (paddr == rom_pkg::OFS_CTRL) prdata = ctrl_reg;
        else if (paddr == rom_pkg::OFS_MODE) prdata = mode_reg;
        else if (paddr == rom_pkg::OFS_DELAY) prdata = delay_reg;
        else if (paddr == rom_pkg::OFS_STILL) prdata = still_reg;
        else if (paddr == rom_pkg::OFS_STATUS) prdata = status;
        else prdata = 32'h0000_0000;
    end
endmodule

// File: dv/rom_remote.sv
// Purpose: Remote enable source and front key model
// Assumes: Levels change only just after a rising edge
// Notes:   Levels are held static, never pulsed
`timescale 1ns/1ps
module rom_remote (
    // Clock
    input  wire logic pclk,
    // Commanded levels
    input  wire logic run_cmd,
    input  wire logic key_cmd,
    // Levels towards the block
    output logic      control_input_one,
    output logic      key_up
);
    // Static level operation only
    always @(posedge pclk) begin
        control_input_one <= run_cmd;
        key_up            <= key_cmd;
    end
endmodule

// File: dv/test_relay_override_and_motion_monitor.sv
// Purpose: Self-checking bench for rom_top
// Assumes: Zero wait APB, small delay and standstill counts
// Notes:   Output two carries the underspeed function
`timescale 1ns/1ps
module test_relay_override_and_motion_monitor;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        key_up, control_input_one, run_cmd, key_cmd, err;
    logic [2:0]  thr_active;
    logic        speed_moving, speed_below_low, standstill;
    logic        o1, o2, o3, ind;
    int          error_cnt, checks;
    // ------------------------------------------------------------
    // Clock, stimulus defaults, reset
    // ------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {run_cmd, key_cmd, thr_active, speed_moving, speed_below_low, standstill} = '0;
        error_cnt = 0;
        checks = 0;
        presetn = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
    end
    rom_remote far (.pclk(pclk), .run_cmd(run_cmd), .key_cmd(key_cmd),
                    .control_input_one(control_input_one), .key_up(key_up));
    rom_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
                 .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
                 .key_up(key_up), .control_input_one(control_input_one), .thr_active(thr_active),
                 .speed_moving(speed_moving), .speed_below_low(speed_below_low),
                 .standstill(standstill), .switch_output_one(o1), .switch_output_two(o2),
                 .switch_output_three(o3), .motion_disabled_ind(ind));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic ctrl(input logic [3:0] sel, input logic [2:0] pat, input logic [3:0] keyf,
                        input logic [3:0] in1f, input logic in1p);
        apb(1'b1, rom_pkg::OFS_CTRL, {11'h000, in1p, in1f, keyf, 4'h0, 1'b0, pat, sel});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic outs(input logic [2:0] exp);
        chk({29'h0, o3, o2, o1}, {29'h0, exp});
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        apb(1'b0, rom_pkg::OFS_CTRL, 32'h0);
        chk(rd, 32'h0000_0000);
        chk({31'h0, err}, 32'h0);
        apb(1'b0, rom_pkg::OFS_MODE, 32'h0);
        chk(rd, 32'h0000_0110);
        apb(1'b0, 8'h14, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, rom_pkg::OFS_MODE, 32'h0000_0010);
        apb(1'b1, rom_pkg::OFS_DELAY, 32'h0000_000A);
        apb(1'b0, rom_pkg::OFS_DELAY, 32'h0);
        chk(rd, 32'h0000_000A);
        apb(1'b1, rom_pkg::OFS_STILL, 32'h0000_0014);
    endtask
    task automatic t_override;
        thr_active <= 3'b111;
        ctrl(4'h5, 3'h2, 4'h2, 4'h0, 1'b0);
        cyc(4);
        outs(3'b111);
        key_cmd <= 1'b1;
        cyc(6);
        outs(3'b010);
        thr_active <= 3'b000;
        cyc(4);
        outs(3'b000);
        thr_active <= 3'b101;
        key_cmd <= 1'b0;
        cyc(6);
        outs(3'b101);
    endtask
    task automatic t_freeze;
        ctrl(4'h8, 3'h0, 4'h0, 4'h2, 1'b0);
        run_cmd <= 1'b1;
        cyc(6);
        thr_active <= 3'b010;
        cyc(6);
        outs(3'b101);
        run_cmd <= 1'b0;
        cyc(6);
        outs(3'b010);
        thr_active <= 3'b000;
    endtask
    task automatic t_monitor;
        standstill <= 1'b1;
        ctrl(4'h0, 3'h0, 4'h0, 4'hC, 1'b0);
        cyc(6);
        chk({31'h0, ind}, 32'h1);
        apb(1'b0, rom_pkg::OFS_STATUS, 32'h0);
        chk({30'h0, rd[4], rd[0]}, 32'h3);
        cyc(30);
        chk({31'h0, o2}, 32'h0);
        speed_moving <= 1'b1;
        standstill   <= 1'b0;
        cyc(40);
        chk({31'h0, o2}, 32'h1);
        run_cmd <= 1'b1;
        cyc(6);
        chk({30'h0, ind, o2}, 32'h0);
        speed_below_low <= 1'b1;
        cyc(3);
        chk({31'h0, o2}, 32'h0);
        cyc(40);
        chk({30'h0, o3, o2}, 32'h1);
        speed_below_low <= 1'b0;
        run_cmd <= 1'b0;
        cyc(40);
        chk({30'h0, o3, o2}, 32'h1);
        speed_moving <= 1'b0;
        standstill <= 1'b1;
        cyc(40);
        chk({31'h0, o2}, 32'h0);
        ctrl(4'h0, 3'h0, 4'h0, 4'hC, 1'b1);
        cyc(6);
        chk({31'h0, ind}, 32'h0);
        cyc(30);
        chk({31'h0, o2}, 32'h1);
        run_cmd <= 1'b1;
        cyc(6);
        chk({31'h0, ind}, 32'h1);
    endtask
    // ------------------------------------------------------------
    // Verdict and watchdog
    // ------------------------------------------------------------
    task automatic stop_test;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #800000;
        error_cnt++;
        stop_test();
    end
    initial begin
        wait (presetn === 1'b1);
        cyc(2);
        t_regs();
        t_override();
        t_freeze();
        t_monitor();
        stop_test();
    end
endmodule
